// *** core/icrm_pkg.sv ***
// icrm_pkg: constants used by the interval counter; its decrementer uses none of them
// assumes: three 16-bit counters behind an 8-bit strobed host port
package icrm_pkg;
	// counter array shape
	localparam int NUM_CNT = 3;
	localparam int CNT_W = 16;
	localparam int BYTE_W = 8;
	localparam int MODE_W = 6;
	// port select codes on the host bus
	localparam logic [1:0] PORT_CTRL = 2'h3;
	// control word field positions
	localparam int CW_SEL_HI = 7;
	localparam int CW_SEL_LO = 6;
	localparam int CW_RW_HI = 5;
	localparam int CW_RW_LO = 4;
	localparam int CW_BCD = 0;
	localparam logic [1:0] SEL_READBACK = 2'h3;
	// readback command fields, latch bits are active low
	localparam int RB_NO_COUNT = 5;
	localparam int RB_NO_STATUS = 4;
	localparam int RB_SEL_BASE = 1;
	// access formats
	localparam logic [1:0] RW_LATCH = 2'h0;
	localparam logic [1:0] RW_LSB = 2'h1;
	localparam logic [1:0] RW_MSB = 2'h2;
	localparam logic [1:0] RW_BOTH = 2'h3;
	// status byte layout
	localparam int ST_OUT = 7;
	localparam int ST_NULL = 6;
	// reset and comparison values
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [5:0] MODE_RST = 6'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
endpackage : icrm_pkg

// *** core/icrm_decrement.sv ***
// icrm_decrement: one-step down count in binary or four-digit decimal
// assumes: width is a multiple of four when decimal counting is used
`timescale 1ns/10ps
module icrm_decrement #(
	parameter int W = 16
) (
	input wire logic [W-1:0] value, // present count
	input wire logic decimal, // high selects decimal digits
	output logic [W-1:0] next_value // count minus one, wrapping at zero
);
	// binary wraps 0 to all ones, decimal wraps 0 to all nines
	always_comb begin
		logic borrow;
		borrow = 1'b1;
		next_value = value - W'(1);
		if (decimal) begin
			for (int k = 0; k < W / 4; k++) begin
				if (borrow && value[4*k +: 4] == 4'h0) begin
					next_value[4*k +: 4] = 4'h9;
				end else if (borrow) begin
					next_value[4*k +: 4] = value[4*k +: 4] - 4'h1;
					borrow = 1'b0;
				end else begin
					next_value[4*k +: 4] = value[4*k +: 4];
				end
			end
		end
	end
endmodule : icrm_decrement

// *** core/icrm_timer.sv ***
// icrm_timer: three-channel interval counter, readback and status latching
// assumes: host strobes and counter clock/gate pins are synchronous to CLK
`timescale 1ns/10ps
module icrm_timer (
	input wire logic CLK, // system clock, 125 MHz
	input wire logic RESET, // synchronous reset, active high
	input wire logic CE, // clock enable, state frozen while low
	input wire logic CS_N, // chip select, active low
	input wire logic RD_N, // read strobe, active low
	input wire logic WR_N, // write strobe, active low
	input wire logic PORT_SELECT_HI, // port select high bit
	input wire logic PORT_SELECT_LO, // port select low bit
	input wire logic [7:0] D_IN, // data bus input
	output logic [7:0] D_OUT, // data bus output
	output logic D_OE, // data bus output enable, high while driving
	input wire logic [2:0] CNT_CLK, // counter clock inputs
	input wire logic [2:0] CNT_GATE, // counter gate inputs
	output logic [2:0] CNT_OUT // counter outputs
);
	localparam int N = icrm_pkg::NUM_CNT;
	localparam int W = icrm_pkg::CNT_W;

	logic [1:0] port_sel;
	logic wr_act, rd_act, wr_start, rd_end;
	logic wr_act_q, wr_act_d, rd_act_q, rd_act_d;
	logic [1:0] rd_addr_q, rd_addr_d;
	logic [7:0] dout_q, dout_d;
	logic doe_q, doe_d;
	logic [N-1:0] tick, rb_cnt, rb_stat;
	logic [W-1:0] dec_val [N];
	logic [5:0] mode_q [N];
	logic [5:0] mode_d [N];
	logic [W-1:0] hold_q [N];
	logic [W-1:0] hold_d [N];
	logic [W-1:0] cnt_q [N];
	logic [W-1:0] cnt_d [N];
	logic [W-1:0] latch_q [N];
	logic [W-1:0] latch_d [N];
	logic [7:0] stat_q [N];
	logic [7:0] stat_d [N];
	logic [N-1:0] cnt_latched_q, cnt_latched_d, stat_latched_q, stat_latched_d;
	logic [N-1:0] null_q, null_d, out_q, out_d, wr_msb_q, wr_msb_d, rd_msb_q, rd_msb_d;
	logic [N-1:0] load_q, load_d, armed_q, armed_d, halt_q, halt_d, wrapped_q, wrapped_d;
	logic [N-1:0] clk_s_q, clk_s_d;

	// bus decode and strobe edges
	assign port_sel = {PORT_SELECT_HI, PORT_SELECT_LO};
	assign wr_act = !CS_N && !WR_N && RD_N;
	assign rd_act = !CS_N && !RD_N && WR_N && port_sel != icrm_pkg::PORT_CTRL;
	assign wr_start = wr_act && !wr_act_q;
	assign rd_end = rd_act_q && !rd_act;

	// per-counter decrementer and readback select decode
	for (genvar i = 0; i < N; i++) begin : g_chan
		icrm_decrement #(.W(W)) u_dec (
			.value(cnt_q[i]),
			.decimal(mode_q[i][icrm_pkg::CW_BCD]),
			.next_value(dec_val[i])
		);
		assign tick[i] = clk_s_q[i] && !CNT_CLK[i];
		assign rb_cnt[i] = wr_start && port_sel == icrm_pkg::PORT_CTRL
			&& D_IN[icrm_pkg::CW_SEL_HI:icrm_pkg::CW_SEL_LO] == icrm_pkg::SEL_READBACK
			&& D_IN[icrm_pkg::RB_SEL_BASE + i] && !D_IN[icrm_pkg::RB_NO_COUNT];
		assign rb_stat[i] = wr_start && port_sel == icrm_pkg::PORT_CTRL
			&& D_IN[icrm_pkg::CW_SEL_HI:icrm_pkg::CW_SEL_LO] == icrm_pkg::SEL_READBACK
			&& D_IN[icrm_pkg::RB_SEL_BASE + i] && !D_IN[icrm_pkg::RB_NO_STATUS];
	end

	// read data mux: latched status first, then latched or live count
	always_comb begin
		logic [W-1:0] val;
		logic [1:0] fmt;
		val = icrm_pkg::CNT_RST;
		fmt = icrm_pkg::RW_LSB;
		dout_d = icrm_pkg::BYTE_RST;
		wr_act_d = wr_act;
		rd_act_d = rd_act;
		rd_addr_d = rd_act ? port_sel : rd_addr_q;
		doe_d = rd_act;
		for (int i = 0; i < N; i++) begin
			if (port_sel == 2'(i)) begin
				fmt = mode_q[i][icrm_pkg::CW_RW_HI:icrm_pkg::CW_RW_LO];
				val = cnt_latched_q[i] ? latch_q[i] : cnt_q[i];
				if (stat_latched_q[i]) begin
					dout_d = stat_q[i];
				end else if (fmt == icrm_pkg::RW_MSB || (fmt == icrm_pkg::RW_BOTH && rd_msb_q[i])) begin
					dout_d = val[15:8];
				end else begin
					dout_d = val[7:0];
				end
			end
		end
	end

	// bus state registers
	always_ff @(posedge CLK) begin
		if (RESET) begin
			wr_act_q <= 1'b0;
			rd_act_q <= 1'b0;
			rd_addr_q <= 2'h0;
			dout_q <= icrm_pkg::BYTE_RST;
			doe_q <= 1'b0;
		end else if (CE) begin
			wr_act_q <= wr_act_d;
			rd_act_q <= rd_act_d;
			rd_addr_q <= rd_addr_d;
			dout_q <= dout_d;
			doe_q <= doe_d;
		end
	end

	// counter channels: counting, then host reads, then host writes (writes win)
	always_comb begin
		logic [1:0] fmt;
		logic [1:0] sel;
		fmt = icrm_pkg::RW_LATCH;
		sel = D_IN[icrm_pkg::CW_SEL_HI:icrm_pkg::CW_SEL_LO];
		for (int i = 0; i < N; i++) begin
			fmt = mode_q[i][icrm_pkg::CW_RW_HI:icrm_pkg::CW_RW_LO];
			mode_d[i] = mode_q[i];
			hold_d[i] = hold_q[i];
			cnt_d[i] = cnt_q[i];
			latch_d[i] = latch_q[i];
			stat_d[i] = stat_q[i];
			cnt_latched_d[i] = cnt_latched_q[i];
			stat_latched_d[i] = stat_latched_q[i];
			null_d[i] = null_q[i];
			out_d[i] = out_q[i];
			wr_msb_d[i] = wr_msb_q[i];
			rd_msb_d[i] = rd_msb_q[i];
			load_d[i] = load_q[i];
			armed_d[i] = armed_q[i];
			halt_d[i] = halt_q[i];
			wrapped_d[i] = wrapped_q[i];
			clk_s_d[i] = CNT_CLK[i];
			// clock pulse: load pending count or decrement
			if (tick[i]) begin
				if (load_q[i]) begin
					cnt_d[i] = hold_q[i];
					load_d[i] = 1'b0;
					null_d[i] = 1'b0;
					armed_d[i] = 1'b1;
					wrapped_d[i] = 1'b0;
				end else if (armed_q[i] && CNT_GATE[i] && !halt_q[i]) begin
					cnt_d[i] = dec_val[i];
					if (cnt_q[i] == icrm_pkg::CNT_ONE) begin
						out_d[i] = 1'b1;
					end
					if (cnt_q[i] == icrm_pkg::CNT_ZERO) begin
						wrapped_d[i] = 1'b1;
					end
				end
			end
			// end of a read of this counter releases one latched item, the count only after its last byte
			if (rd_end && rd_addr_q == 2'(i)) begin
				if (stat_latched_q[i]) begin
					stat_latched_d[i] = 1'b0;
				end else if (fmt == icrm_pkg::RW_BOTH && !rd_msb_q[i]) begin
					rd_msb_d[i] = 1'b1;
				end else begin
					rd_msb_d[i] = 1'b0;
					cnt_latched_d[i] = 1'b0;
				end
			end
			// count write to this counter
			if (wr_start && port_sel == 2'(i)) begin
				if (fmt == icrm_pkg::RW_BOTH && !wr_msb_q[i]) begin
					hold_d[i][7:0] = D_IN;
					wr_msb_d[i] = 1'b1;
					out_d[i] = 1'b0;
					if (!wrapped_q[i]) begin
						halt_d[i] = 1'b1;
					end
				end else begin
					if (fmt == icrm_pkg::RW_LSB) begin
						hold_d[i] = {icrm_pkg::BYTE_RST, D_IN};
					end else if (fmt == icrm_pkg::RW_MSB) begin
						hold_d[i] = {D_IN, icrm_pkg::BYTE_RST};
					end else begin
						hold_d[i][15:8] = D_IN;
					end
					wr_msb_d[i] = 1'b0;
					load_d[i] = 1'b1;
					null_d[i] = 1'b1;
					halt_d[i] = 1'b0;
					out_d[i] = 1'b0;
				end
			end
			// control word or counter latch command aimed at this counter
			if (wr_start && port_sel == icrm_pkg::PORT_CTRL && sel == 2'(i)) begin
				if (D_IN[icrm_pkg::CW_RW_HI:icrm_pkg::CW_RW_LO] == icrm_pkg::RW_LATCH) begin
					if (!cnt_latched_q[i]) begin
						latch_d[i] = cnt_q[i];
						cnt_latched_d[i] = 1'b1;
					end
				end else begin
					mode_d[i] = D_IN[5:0];
					null_d[i] = 1'b1;
					out_d[i] = 1'b0;
					wr_msb_d[i] = 1'b0;
					rd_msb_d[i] = 1'b0;
					cnt_latched_d[i] = 1'b0;
					stat_latched_d[i] = 1'b0;
					load_d[i] = 1'b0;
					armed_d[i] = 1'b0;
					halt_d[i] = 1'b0;
				end
			end
			// readback command: independent count and status requests
			if (rb_cnt[i] && !cnt_latched_q[i]) begin
				latch_d[i] = cnt_q[i];
				cnt_latched_d[i] = 1'b1;
			end
			if (rb_stat[i] && !stat_latched_q[i]) begin
				stat_d[i] = {out_q[i], null_q[i], mode_q[i]};
				stat_latched_d[i] = 1'b1;
			end
		end
	end

	// counter channel registers
	always_ff @(posedge CLK) begin
		if (RESET) begin
			for (int i = 0; i < N; i++) begin
				mode_q[i] <= icrm_pkg::MODE_RST;
				hold_q[i] <= icrm_pkg::CNT_RST;
				cnt_q[i] <= icrm_pkg::CNT_RST;
				latch_q[i] <= icrm_pkg::CNT_RST;
				stat_q[i] <= icrm_pkg::BYTE_RST;
			end
			cnt_latched_q <= '0;
			stat_latched_q <= '0;
			null_q <= '0;
			out_q <= '0;
			wr_msb_q <= '0;
			rd_msb_q <= '0;
			load_q <= '0;
			armed_q <= '0;
			halt_q <= '0;
			wrapped_q <= '0;
			clk_s_q <= '0;
		end else if (CE) begin
			for (int i = 0; i < N; i++) begin
				mode_q[i] <= mode_d[i];
				hold_q[i] <= hold_d[i];
				cnt_q[i] <= cnt_d[i];
				latch_q[i] <= latch_d[i];
				stat_q[i] <= stat_d[i];
			end
			cnt_latched_q <= cnt_latched_d;
			stat_latched_q <= stat_latched_d;
			null_q <= null_d;
			out_q <= out_d;
			wr_msb_q <= wr_msb_d;
			rd_msb_q <= rd_msb_d;
			load_q <= load_d;
			armed_q <= armed_d;
			halt_q <= halt_d;
			wrapped_q <= wrapped_d;
			clk_s_q <= clk_s_d;
		end
	end

	// outputs straight from flip-flops
	assign D_OUT = dout_q;
	assign D_OE = doe_q;
	assign CNT_OUT = out_q;

	// checks on each channel
	for (genvar i = 0; i < N; i++) begin : g_chk
		sequence cw_to_chan;
			CE && wr_start && port_sel == icrm_pkg::PORT_CTRL && D_IN[7:6] == 2'(i)
				&& D_IN[5:4] != icrm_pkg::RW_LATCH;
		endsequence
		sequence rd_both_latched;
			CE && rd_end && rd_addr_q == 2'(i) && stat_latched_q[i] && cnt_latched_q[i];
		endsequence
		sequence bus_quiet;
			CE && !wr_start && !rd_end;
		endsequence
		load_clears_null_a: assert property (@(posedge CLK) disable iff (RESET)
			(bus_quiet and (tick[i] && load_q[i])) |=> !null_q[i] && cnt_q[i] == $past(hold_q[i]))
			else $error("pending load did not clear null flag");
		cw_sets_null_a: assert property (@(posedge CLK) disable iff (RESET)
			cw_to_chan |=> null_q[i] && !out_q[i] && !load_q[i])
			else $error("control word did not flag pending load");
		latch_frozen_a: assert property (@(posedge CLK) disable iff (RESET)
			(bus_quiet and cnt_latched_q[i]) |=> $stable(latch_q[i]) && cnt_latched_q[i])
			else $error("latched count changed before read");
		second_latch_a: assert property (@(posedge CLK) disable iff (RESET)
			(CE && rb_cnt[i] && cnt_latched_q[i]) |=> $stable(latch_q[i]))
			else $error("second count latch was not ignored");
		status_layout_a: assert property (@(posedge CLK) disable iff (RESET)
			(CE && rb_stat[i] && !stat_latched_q[i]) |=> stat_latched_q[i]
				&& stat_q[i][icrm_pkg::ST_OUT] == $past(out_q[i])
				&& stat_q[i][icrm_pkg::ST_NULL] == $past(null_q[i]))
			else $error("status byte layout wrong");
		status_first_a: assert property (@(posedge CLK) disable iff (RESET)
			rd_both_latched |=> !stat_latched_q[i] && cnt_latched_q[i])
			else $error("status was not consumed before latched count");
		out_rise_zero_a: assert property (@(posedge CLK) disable iff (RESET)
			(bus_quiet and (tick[i] && !load_q[i] && armed_q[i] && CNT_GATE[i] && !halt_q[i]
				&& cnt_q[i] == icrm_pkg::CNT_ONE)) |=> out_q[i] && cnt_q[i] == icrm_pkg::CNT_ZERO)
			else $error("output did not rise at terminal count");
		gate_hold_a: assert property (@(posedge CLK) disable iff (RESET)
			(bus_quiet and (!CNT_GATE[i] && !load_q[i])) |=> $stable(cnt_q[i]) && $stable(out_q[i]))
			else $error("count moved while gate low");
		halt_holds_a: assert property (@(posedge CLK) disable iff (RESET)
			(bus_quiet and (tick[i] && halt_q[i] && !load_q[i])) |=> $stable(cnt_q[i]))
			else $error("halted counter moved");
		msb_sets_null_a: assert property (@(posedge CLK) disable iff (RESET)
			(CE && wr_start && port_sel == 2'(i) && wr_msb_q[i])
				|=> null_q[i] && load_q[i])
			else $error("second count byte did not flag pending load");
	end
	read_oe_a: assert property (@(posedge CLK) disable iff (RESET)
		(CE && (CS_N || RD_N || !WR_N || port_sel == icrm_pkg::PORT_CTRL)) |=> !D_OE)
		else $error("data bus driven outside a read");
endmodule : icrm_timer

// *** verification/icrm_host.sv ***
// icrm_host: host processor model on the strobed 8-bit port
// assumes: tasks are entered just after a rising edge of clk
`timescale 1ns/10ps
module icrm_host (
	input wire logic clk, // system clock
	input wire logic [7:0] d_out, // device read data
	input wire logic d_oe, // device drives the bus
	output logic cs_n, // chip select, active low
	output logic rd_n, // read strobe, active low
	output logic wr_n, // write strobe, active low
	output logic [1:0] sel, // port select
	output logic [7:0] d_in // write data
);
	// bus idle from time zero
	initial begin
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		wr_n <= 1'b1;
		sel <= 2'h0;
		d_in <= 8'h00;
	end

	// one write, strobe for one clock, then one idle clock
	task automatic wr(input logic [1:0] s, input logic [7:0] v);
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		sel <= s;
		d_in <= v;
		@(posedge clk);
		cs_n <= 1'b1;
		wr_n <= 1'b1;
		d_in <= ~v; // released data never repeats the last byte
		@(posedge clk);
	endtask : wr

	// one byte read, held up to three clocks for the device to drive, ok low if it does not
	task automatic rd(input logic [1:0] s, output logic [7:0] v, output logic ok);
		ok = 1'b0;
		v = 8'h00;
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		sel <= s;
		for (int i = 0; i < 3 && !ok; i++) begin
			@(posedge clk);
			#1;
			ok = (d_oe === 1'b1);
			v = d_out;
		end
		@(posedge clk);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		@(posedge clk);
		@(posedge clk);
	endtask : rd
endmodule : icrm_host

// *** verification/test_interval_counter_readback_mode0.sv ***
// test_interval_counter_readback_mode0: self-checking bench for icrm_timer
// assumes: icrm_host drives the bus, the bench drives counter clocks and gates
`timescale 1ns/10ps
module test_interval_counter_readback_mode0;
	logic clk;
	logic reset;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic [1:0] sel;
	logic [7:0] d_in;
	logic [7:0] d_out;
	logic d_oe;
	logic [2:0] cnt_clk;
	logic [2:0] cnt_gate;
	logic [2:0] cnt_out;
	int n_mismatch;
	int n_tests;

	// device under test and host model
	icrm_timer i_icrm_timer (.CLK(clk), .RESET(reset), .CE(1'b1), .CS_N(cs_n),
		.RD_N(rd_n), .WR_N(wr_n), .PORT_SELECT_HI(sel[1]), .PORT_SELECT_LO(sel[0]),
		.D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe), .CNT_CLK(cnt_clk),
		.CNT_GATE(cnt_gate), .CNT_OUT(cnt_out));
	icrm_host i_icrm_host (.clk(clk), .d_out(d_out), .d_oe(d_oe), .cs_n(cs_n),
		.rd_n(rd_n), .wr_n(wr_n), .sel(sel), .d_in(d_in));

	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// compare tasks, one per kind of result
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk8

	task automatic chk1(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %b seen %b", nm, e, g);
		end
	endtask : chk1

	// counter clock pulses: high one clock, low two, output settles meanwhile
	task automatic pulse(input int ch, input int n);
		repeat (n) begin
			cnt_clk[ch] <= 1'b1;
			@(posedge clk);
			cnt_clk[ch] <= 1'b0;
			@(posedge clk);
			@(posedge clk);
		end
	endtask : pulse

	// read a byte and compare it
	task automatic rdc(input logic [1:0] s, input logic [7:0] e, input string nm);
		logic [7:0] v;
		logic ok;
		i_icrm_host.rd(s, v, ok);
		chk1({nm, " drive"}, 1'b1, ok);
		chk8(nm, e, v);
	endtask : rdc

	// compare a counter output once settled, then back onto the rising edge
	task automatic outc(input int ch, input logic e, input string nm);
		#1;
		chk1(nm, e, cnt_out[ch]);
		@(posedge clk);
	endtask : outc

	// programming, status contents and the N+1 pulse count
	task automatic t_mode0();
		i_icrm_host.wr(2'h3, 8'h30);
		i_icrm_host.wr(2'h3, 8'hE2);
		rdc(2'h0, 8'h70, "status c0 after cw");
		i_icrm_host.wr(2'h3, 8'hE4);
		rdc(2'h1, 8'h00, "status c1 untouched");
		i_icrm_host.wr(2'h0, 8'h03);
		i_icrm_host.wr(2'h0, 8'h00);
		pulse(0, 3);
		outc(0, 1'b0, "out0 after N pulses");
		pulse(0, 1);
		outc(0, 1'b1, "out0 after N+1 pulses");
		i_icrm_host.wr(2'h3, 8'hE2);
		rdc(2'h0, 8'hB0, "status c0 loaded");
		$display("t_mode0 done");
	endtask : t_mode0

	// new two-byte count while the output is high
	task automatic t_rewrite();
		i_icrm_host.wr(2'h0, 8'h05);
		outc(0, 1'b0, "out0 after lsb");
		i_icrm_host.wr(2'h3, 8'hE2);
		rdc(2'h0, 8'h30, "status after lsb");
		i_icrm_host.wr(2'h0, 8'h00);
		i_icrm_host.wr(2'h3, 8'hE2);
		rdc(2'h0, 8'h70, "status after msb");
		pulse(0, 5);
		outc(0, 1'b0, "out0 before expiry");
		pulse(0, 1);
		outc(0, 1'b1, "out0 after new count");
		$display("t_rewrite done");
	endtask : t_rewrite

	// count latch frozen, repeat ignored, released by reading
	task automatic t_latch();
		i_icrm_host.wr(2'h3, 8'h70);
		i_icrm_host.wr(2'h1, 8'h0A);
		i_icrm_host.wr(2'h1, 8'h00);
		pulse(1, 1);
		i_icrm_host.wr(2'h3, 8'hD4);
		pulse(1, 2);
		i_icrm_host.wr(2'h3, 8'hD4);
		rdc(2'h1, 8'h0A, "latched lsb");
		rdc(2'h1, 8'h00, "latched msb");
		rdc(2'h1, 8'h08, "live lsb");
		rdc(2'h1, 8'h00, "live msb");
		$display("t_latch done");
	endtask : t_latch

	// count and status latched together, status read first
	task automatic t_both();
		i_icrm_host.wr(2'h3, 8'hC4);
		pulse(1, 1);
		i_icrm_host.wr(2'h3, 8'hC4);
		rdc(2'h1, 8'h30, "status first");
		rdc(2'h1, 8'h08, "latched lsb");
		rdc(2'h1, 8'h00, "latched msb");
		rdc(2'h1, 8'h07, "unlatched lsb");
		rdc(2'h1, 8'h00, "unlatched msb");
		$display("t_both done");
	endtask : t_both

	// gate low loads but holds, old value before load, N pulses after gate
	task automatic t_gate();
		i_icrm_host.wr(2'h3, 8'hB0);
		i_icrm_host.wr(2'h2, 8'h02);
		i_icrm_host.wr(2'h2, 8'h00);
		pulse(2, 3);
		rdc(2'h2, 8'h02, "held lsb");
		rdc(2'h2, 8'h00, "held msb");
		i_icrm_host.wr(2'h2, 8'h05);
		i_icrm_host.wr(2'h2, 8'h00);
		rdc(2'h2, 8'h02, "old lsb before load");
		rdc(2'h2, 8'h00, "old msb before load");
		pulse(2, 1);
		outc(2, 1'b0, "out2 gate low");
		cnt_gate[2] <= 1'b1;
		pulse(2, 4);
		outc(2, 1'b0, "out2 before N");
		pulse(2, 1);
		outc(2, 1'b1, "out2 at N");
		$display("t_gate done");
	endtask : t_gate

	// read at the control port leaves the bus undriven
	task automatic t_decode();
		logic [7:0] v;
		logic ok;
		i_icrm_host.rd(2'h3, v, ok);
		chk1("drive at control port", 1'b0, ok);
		$display("t_decode done");
	endtask : t_decode

	// decimal counting, one-byte formats and the counter latch command
	task automatic t_formats();
		i_icrm_host.wr(2'h3, 8'h51);
		i_icrm_host.wr(2'h1, 8'h10);
		pulse(1, 2);
		rdc(2'h1, 8'h09, "decimal lsb");
		i_icrm_host.wr(2'h3, 8'h40);
		pulse(1, 1);
		rdc(2'h1, 8'h09, "latch command");
		rdc(2'h1, 8'h08, "live after latch");
		i_icrm_host.wr(2'h3, 8'h60);
		i_icrm_host.wr(2'h1, 8'h01);
		pulse(1, 1);
		rdc(2'h1, 8'h01, "msb only");
		i_icrm_host.wr(2'h3, 8'hE4);
		rdc(2'h1, 8'h20, "status msb format");
		$display("t_formats done");
	endtask : t_formats

	// low byte before wrap halts, after wrap not; first status kept; per-counter latches
	task automatic t_halt();
		i_icrm_host.wr(2'h0, 8'h01);
		i_icrm_host.wr(2'h0, 8'h00);
		pulse(0, 3);
		i_icrm_host.wr(2'h0, 8'h07);
		pulse(0, 2);
		i_icrm_host.wr(2'h3, 8'hD2);
		rdc(2'h0, 8'hFD, "after wrap lsb");
		rdc(2'h0, 8'hFF, "after wrap msb");
		i_icrm_host.wr(2'h0, 8'h00);
		pulse(0, 2);
		i_icrm_host.wr(2'h0, 8'h09);
		pulse(0, 2);
		i_icrm_host.wr(2'h3, 8'hD2);
		rdc(2'h0, 8'h06, "halted lsb");
		rdc(2'h0, 8'h00, "halted msb");
		i_icrm_host.wr(2'h0, 8'h00);
		i_icrm_host.wr(2'h3, 8'hE2);
		pulse(0, 1);
		i_icrm_host.wr(2'h3, 8'hC6);
		pulse(0, 1);
		pulse(1, 1);
		rdc(2'h0, 8'h70, "first status kept");
		rdc(2'h0, 8'h09, "c0 latched lsb");
		rdc(2'h0, 8'h00, "c0 latched msb");
		rdc(2'h1, 8'h20, "c1 status");
		rdc(2'h1, 8'h01, "c1 still latched");
		rdc(2'h1, 8'h00, "c1 live msb");
		$display("t_halt done");
	endtask : t_halt

	// counts and verdict, then end of run
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop

	// main sequence
	initial begin
		n_mismatch = 0;
		n_tests = 0;
		reset <= 1'b1;
		cnt_clk <= 3'h0;
		cnt_gate <= 3'h3;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_mode0();
		t_rewrite();
		t_latch();
		t_both();
		t_formats();
		t_halt();
		t_gate();
		t_decode();
		report_and_stop();
	end

	// watchdog: the run needs well under a thousand clocks
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		report_and_stop();
	end
endmodule : test_interval_counter_readback_mode0
